// >>> hw/pllsd_divider.sv
// Programmable pulse divider used as the reference counter
`default_nettype none
module pllsd_divider #(
   parameter int W = pllsd_pkg::REF_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic tick,
   input wire logic [W-1:0] ratio,
   output logic pulse_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic pulse;
   } pllsd_div_s;

   pllsd_div_s st_r;
   pllsd_div_s st_nxt;
   logic wrap;

   assign wrap = st_r.cnt >= (ratio - W'(1));

   always_comb begin
      st_nxt = st_r;
      st_nxt.pulse = 1'b0;
      if (tick) begin
         if (wrap) begin
            st_nxt.cnt = '0;
            st_nxt.pulse = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign pulse_o = st_r.pulse;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_div_wrap_pulse: assert property (ce && tick && wrap |=> pulse_o && st_r.cnt == '0)
      else $error("divider did not pulse at wrap");
   a_div_no_early: assert property (ce && !(tick && wrap) |=> !pulse_o)
      else $error("divider pulsed without wrap");
endmodule // pllsd_divider
`default_nettype wire

// >>> hw/pllsd_phase_det.sv
// Phase-frequency comparator with selectable polarity
`default_nettype none
module pllsd_phase_det (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic ref_pulse,
   input wire logic vco_pulse,
   input wire logic pol_normal,
   output logic pump_up,
   output logic pump_down
);
   typedef struct packed {
      logic ref_ahead;
      logic vco_ahead;
      logic up;
      logic down;
   } pllsd_pd_s;

   pllsd_pd_s st_r;
   pllsd_pd_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ref_ahead = st_r.ref_ahead || ref_pulse;
      st_nxt.vco_ahead = st_r.vco_ahead || vco_pulse;
      if (st_nxt.ref_ahead && st_nxt.vco_ahead) begin
         st_nxt.ref_ahead = 1'b0;
         st_nxt.vco_ahead = 1'b0;
      end
      // Low polarity select swaps pump sense
      st_nxt.up = pol_normal ? st_nxt.ref_ahead : st_nxt.vco_ahead;
      st_nxt.down = pol_normal ? st_nxt.vco_ahead : st_nxt.ref_ahead;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign pump_up = st_r.up;
   assign pump_down = st_r.down;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ref_leads;
      ce && ref_pulse && !vco_pulse && !st_r.ref_ahead && !st_r.vco_ahead;
   endsequence

   a_pol_normal: assert property (s_ref_leads ##0 pol_normal |=> pump_up && !pump_down)
      else $error("reference lead did not pump up");
   a_pol_invert: assert property (s_ref_leads ##0 !pol_normal |=> pump_down && !pump_up)
      else $error("inverted polarity not applied");
endmodule // pllsd_phase_det
`default_nettype wire

// >>> hw/pllsd_pkg.sv
// Shared constants for the serial-programmed PLL divider block
`default_nettype none
package pllsd_pkg;
   // ----------------------------------------
   // Serial frame and latch layout
   // ----------------------------------------
   localparam int SHIFT_W = 19;
   localparam int REF_SHIFT_W = 16;
   localparam int REF_LATCH_W = 15;
   localparam int MAIN_LATCH_W = 18;
   localparam int REF_CNT_W = 14;
   localparam int SWALLOW_W = 7;
   localparam int MAIN_CNT_W = 11;
   localparam int PRESC_W = 8;
   localparam int CTRL_BIT_POS = 0;
   localparam int REF_CNT_LSB = 1;
   localparam int RATIO_SEL_POS = 15;
   localparam int SWALLOW_LSB = 1;
   localparam int MAIN_CNT_LSB = 8;
   localparam int REF_LATCH_SEL_POS = 14;
   localparam int MAIN_LATCH_N_LSB = 7;
   localparam logic [REF_LATCH_W-1:0] REF_LATCH_RST = 15'h4008;
   localparam logic [MAIN_LATCH_W-1:0] MAIN_LATCH_RST = 18'h0_0800;
   localparam logic [REF_CNT_W-1:0] REF_CNT_MIN = 14'h0008;
   localparam logic [MAIN_CNT_W-1:0] MAIN_CNT_MIN = 11'h010;
   localparam logic [PRESC_W-1:0] PRESC_BASE_HI = 8'h40;
   localparam logic [PRESC_W-1:0] PRESC_BASE_LO = 8'h80;
   // ----------------------------------------
   // APB register map
   // ----------------------------------------
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [APB_AW-1:0] REF_OFS = 12'h004;
   localparam logic [APB_AW-1:0] MAIN_OFS = 12'h008;
   localparam logic [APB_AW-1:0] STATUS_OFS = 12'h00c;
   localparam logic [APB_AW-1:0] SHIFT_OFS = 12'h010;
   localparam int CTRL_RUN_POS = 0;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam int STAT_LOCK_POS = 0;
   localparam int STAT_STROBE_POS = 1;
   localparam int STAT_POL_POS = 2;
   localparam int STAT_BAD_POS = 3;
endpackage
`default_nettype wire

// >>> hw/pllsd_top.sv
// PLL serial programming, dividers, phase compare and APB status
// ----------------------------------------
// Summary of operation
// - Each shift clock rising edge shifts serial data into 19- and 16-bit registers.
// - Last frame bit is a control bit choosing the destination latch.
// - Control high and strobe high copy frame into 15-bit reference latch.
// - Control low and strobe high copy frame into 18-bit main latch.
// - Strobe has pull-up; undriven strobe acts as high and transfers.
// - Fast-lock output is high impedance, following pump while strobe high.
// - Lock detect high, low while reference and VCO phases differ.
// - Polarity select has pull-up; low inverts comparator and pump sense.
// - Monitor output shows divided reference or divided VCO per polarity select.
// - Swallow counter is 7 bits, counts 0 to 127.
// - Main counter is 11 bits, counts 16 to 2047.
// - Reference counter is 14 bits, counts 8 to 16383.
// - One latched ratio bit picks prescaler 64/65 or 128/129.
// - Ratio bit high gives base modulus 64, low gives 128.
// - Main frame bits 1-7 set swallow count, 8-18 main count.
// - VCO division totals modulus times main plus swallow; swallow below main.
// ----------------------------------------
//
// Added by the designer: the register addresses and the APB interface to the registers.
`default_nettype none
module pllsd_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pllsd_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_data,
   input wire logic shift_clk,
   input wire logic latch_transfer_strobe,
   input wire logic latch_transfer_strobe_drv,
   input wire logic phase_polarity_select,
   input wire logic phase_polarity_select_drv,
   input wire logic osc_tick,
   input wire logic vco_tick,
   output logic lock_detect_out,
   output logic fast_lock_switch_out_o,
   output logic fast_lock_switch_out_oe,
   output logic divider_monitor_out,
   output logic charge_pump_o,
   output logic charge_pump_oe,
   output logic phase_ref_out,
   output logic phase_vco_out_o,
   output logic phase_vco_out_oe
);
   typedef struct packed {
      logic sck_q;
      logic [pllsd_pkg::SHIFT_W-1:0] sh;
      logic [pllsd_pkg::REF_LATCH_W-1:0] ref_latch;
      logic [pllsd_pkg::MAIN_LATCH_W-1:0] main_latch;
      logic [pllsd_pkg::PRESC_W-1:0] presc_cnt;
      logic [pllsd_pkg::SWALLOW_W-1:0] swal_cnt;
      logic [pllsd_pkg::MAIN_CNT_W-1:0] main_cnt;
      logic divided_vco;
      logic run;
      logic lock;
      logic fl_o;
      logic fl_oe;
      logic cp_o;
      logic cp_oe;
      logic phr;
      logic php_oe;
      logic mon;
      logic rd_vld;
      logic [31:0] rdata;
      logic err;
   } pllsd_top_s;

   pllsd_top_s st_r;
   pllsd_top_s st_nxt;

   logic strobe_lvl;
   logic pol_lvl;
   logic sck_rise;
   logic ratio_sel;
   logic [pllsd_pkg::REF_CNT_W-1:0] ref_ratio;
   logic [pllsd_pkg::SWALLOW_W-1:0] swallow_ratio;
   logic [pllsd_pkg::MAIN_CNT_W-1:0] main_ratio;
   logic [pllsd_pkg::PRESC_W-1:0] presc_base;
   logic [pllsd_pkg::PRESC_W-1:0] modulus;
   logic swal_active;
   logic divided_reference;
   logic pd_up;
   logic pd_down;
   logic setting_bad;
   logic apb_done;
   logic addr_hit;
   logic [31:0] rd_mux;

   // ----------------------------------------
   // Pin levels and latch fields
   // ----------------------------------------
   // Undriven pins resolve high through the pull-ups
   assign strobe_lvl = latch_transfer_strobe_drv ? latch_transfer_strobe : 1'b1;
   assign pol_lvl = phase_polarity_select_drv ? phase_polarity_select : 1'b1;
   assign sck_rise = shift_clk && !st_r.sck_q;
   assign ratio_sel = st_r.ref_latch[pllsd_pkg::REF_LATCH_SEL_POS];
   assign ref_ratio = st_r.ref_latch[pllsd_pkg::REF_CNT_W-1:0];
   assign swallow_ratio = st_r.main_latch[pllsd_pkg::SWALLOW_W-1:0];
   assign main_ratio = st_r.main_latch[pllsd_pkg::MAIN_LATCH_W-1:pllsd_pkg::MAIN_LATCH_N_LSB];
   assign presc_base = ratio_sel ? pllsd_pkg::PRESC_BASE_HI : pllsd_pkg::PRESC_BASE_LO;
   assign swal_active = st_r.swal_cnt < swallow_ratio;
   assign modulus = presc_base + {{(pllsd_pkg::PRESC_W-1){1'b0}}, swal_active};
   assign setting_bad = (ref_ratio < pllsd_pkg::REF_CNT_MIN) || (main_ratio < pllsd_pkg::MAIN_CNT_MIN)
      || ({4'h0, swallow_ratio} >= main_ratio);

   // ----------------------------------------
   // Reference counter and phase comparator
   // ----------------------------------------
   pllsd_divider #(
      .W(pllsd_pkg::REF_CNT_W)
   ) u_ref_div (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(osc_tick && st_r.run),
      .ratio(ref_ratio),
      .pulse_o(divided_reference)
   );

   pllsd_phase_det u_phase_det (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .ref_pulse(divided_reference),
      .vco_pulse(st_r.divided_vco),
      .pol_normal(pol_lvl),
      .pump_up(pd_up),
      .pump_down(pd_down)
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign pready = psel && penable && st_r.rd_vld && ce;
   assign apb_done = pready;

   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      case ({paddr[pllsd_pkg::APB_AW-1:2], 2'b00})
         pllsd_pkg::CTRL_OFS: begin
            rd_mux[pllsd_pkg::CTRL_RUN_POS] = st_r.run;
         end
         pllsd_pkg::REF_OFS: begin
            rd_mux[pllsd_pkg::REF_LATCH_W-1:0] = st_r.ref_latch;
         end
         pllsd_pkg::MAIN_OFS: begin
            rd_mux[pllsd_pkg::MAIN_LATCH_W-1:0] = st_r.main_latch;
         end
         pllsd_pkg::STATUS_OFS: begin
            rd_mux[pllsd_pkg::STAT_LOCK_POS] = st_r.lock;
            rd_mux[pllsd_pkg::STAT_STROBE_POS] = strobe_lvl;
            rd_mux[pllsd_pkg::STAT_POL_POS] = pol_lvl;
            rd_mux[pllsd_pkg::STAT_BAD_POS] = setting_bad;
         end
         pllsd_pkg::SHIFT_OFS: begin
            rd_mux[pllsd_pkg::SHIFT_W-1:0] = st_r.sh;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.sck_q = shift_clk;
      // Both shift registers share one chain; the low 16 bits form the reference one
      if (sck_rise) begin
         st_nxt.sh = {st_r.sh[pllsd_pkg::SHIFT_W-2:0], serial_data};
      end
      // Latches stay transparent while the strobe is high
      if (strobe_lvl) begin
         if (st_r.sh[pllsd_pkg::CTRL_BIT_POS]) begin
            st_nxt.ref_latch = st_r.sh[pllsd_pkg::RATIO_SEL_POS:pllsd_pkg::REF_CNT_LSB];
         end else begin
            st_nxt.main_latch = st_r.sh[pllsd_pkg::SHIFT_W-1:pllsd_pkg::SWALLOW_LSB];
         end
      end
      // Pulse swallow: modulus+1 for the first A prescaler cycles, then modulus
      st_nxt.divided_vco = 1'b0;
      if (st_r.run && vco_tick) begin
         if (st_r.presc_cnt >= modulus - 8'h01) begin
            st_nxt.presc_cnt = '0;
            if (swal_active) begin
               st_nxt.swal_cnt = st_r.swal_cnt + 7'h01;
            end
            if (st_r.main_cnt >= main_ratio - 11'h001) begin
               st_nxt.main_cnt = '0;
               st_nxt.swal_cnt = '0;
               st_nxt.divided_vco = 1'b1;
            end else begin
               st_nxt.main_cnt = st_r.main_cnt + 11'h001;
            end
         end else begin
            st_nxt.presc_cnt = st_r.presc_cnt + 8'h01;
         end
      end
      // Pump, lock and pin drivers
      st_nxt.lock = !(pd_up || pd_down);
      st_nxt.cp_oe = pd_up || pd_down;
      st_nxt.cp_o = pd_up;
      st_nxt.phr = pd_down;
      st_nxt.php_oe = pd_up;
      st_nxt.fl_oe = strobe_lvl && (pd_up || pd_down);
      st_nxt.fl_o = pd_up;
      st_nxt.mon = pol_lvl ? divided_reference : st_r.divided_vco;
      // APB: read data captured in setup, write taken at the access edge
      if (psel && !penable) begin
         st_nxt.rd_vld = 1'b1;
         st_nxt.rdata = rd_mux;
         st_nxt.err = !addr_hit;
      end else if (apb_done) begin
         st_nxt.rd_vld = 1'b0;
      end
      if (apb_done && pwrite && addr_hit
          && {paddr[pllsd_pkg::APB_AW-1:2], 2'b00} == pllsd_pkg::CTRL_OFS) begin
         st_nxt.run = pwdata[pllsd_pkg::CTRL_RUN_POS];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.ref_latch <= pllsd_pkg::REF_LATCH_RST;
         st_r.main_latch <= pllsd_pkg::MAIN_LATCH_RST;
         st_r.run <= pllsd_pkg::CTRL_RUN_RST;
         st_r.lock <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = st_r.rdata;
   assign pslverr = st_r.err;
   assign lock_detect_out = st_r.lock;
   assign fast_lock_switch_out_o = st_r.fl_o;
   assign fast_lock_switch_out_oe = st_r.fl_oe;
   assign divider_monitor_out = st_r.mon;
   assign charge_pump_o = st_r.cp_o;
   assign charge_pump_oe = st_r.cp_oe;
   assign phase_ref_out = st_r.phr;
   assign phase_vco_out_o = 1'b0;
   assign phase_vco_out_oe = st_r.php_oe;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ref_xfer;
      ce && strobe_lvl && st_r.sh[pllsd_pkg::CTRL_BIT_POS];
   endsequence

   sequence s_main_xfer;
      ce && strobe_lvl && !st_r.sh[pllsd_pkg::CTRL_BIT_POS];
   endsequence

   a_shift_in_bit: assert property (ce && sck_rise |=> st_r.sh == {$past(st_r.sh[17:0]), $past(serial_data)})
      else $error("serial bit not shifted in");
   a_shift_hold: assert property (ce && !sck_rise |=> $stable(st_r.sh))
      else $error("shift register moved without clock edge");
   a_ref_latch_load: assert property (s_ref_xfer |=> st_r.ref_latch == $past(st_r.sh[15:1]))
      else $error("reference latch not loaded");
   a_main_latch_load: assert property (s_main_xfer |=> st_r.main_latch == $past(st_r.sh[18:1]))
      else $error("main latch not loaded");
   a_strobe_float: assert property (ce && !latch_transfer_strobe_drv ##0 s_ref_xfer
      |=> st_r.ref_latch == $past(st_r.sh[15:1]))
      else $error("floating strobe did not transfer");
   a_latch_closed: assert property (ce && !strobe_lvl |=> $stable(st_r.ref_latch) && $stable(st_r.main_latch))
      else $error("latch changed with strobe low");
   a_fast_lock_off: assert property (ce && !strobe_lvl |=> !fast_lock_switch_out_oe)
      else $error("fast-lock output driven with strobe low");
   a_fast_lock_on: assert property (ce && strobe_lvl && (pd_up || pd_down)
      |=> fast_lock_switch_out_oe && fast_lock_switch_out_o == $past(pd_up))
      else $error("fast-lock output does not follow pump");
   a_lock_low: assert property (ce && (pd_up || pd_down) |=> !lock_detect_out)
      else $error("lock detect high during phase error");
   a_monitor_sel: assert property (ce |=> divider_monitor_out == ($past(pol_lvl) ? $past(divided_reference)
      : $past(st_r.divided_vco)))
      else $error("monitor output wrong source");
   a_presc_base: assert property (ce && st_r.run && vco_tick && !swal_active
      && st_r.presc_cnt == presc_base - 8'h01 |=> st_r.presc_cnt == '0)
      else $error("prescaler base modulus wrong");
   a_apb_unmapped: assert property (ce && psel && !penable && !addr_hit |=> pslverr)
      else $error("unmapped address not flagged");
endmodule // pllsd_top
`default_nettype wire

// >>> verification/pllsd_host_model.sv
// Host model driving the three-wire serial programming lines
`default_nettype none
module pllsd_host_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [18:0] frame,
   input wire logic [4:0] nbits,
   input wire logic float_le,
   output logic serial_data,
   output logic shift_clk,
   output logic strobe,
   output logic strobe_drv,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   initial begin
      serial_data = 1'b0;
      shift_clk = 1'b0;
      strobe = 1'b0;
      strobe_drv = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge pclk);
         if (go) begin
            busy <= 1'b1;
            for (int i = int'(nbits) - 1; i >= 0; i--) begin
               serial_data <= frame[i];
               shift_clk <= 1'b0;
               repeat (2) @(posedge pclk);
               shift_clk <= 1'b1;
               repeat (2) @(posedge pclk);
            end
            shift_clk <= 1'b0;
            serial_data <= ~frame[0];
            @(posedge pclk);
            // Strobe only after the control bit, or left floating
            strobe <= ~float_le;
            strobe_drv <= ~float_le;
            repeat (3) @(posedge pclk);
            strobe <= 1'b0;
            strobe_drv <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule // pllsd_host_model
`default_nettype wire

// >>> verification/test_pll_serial_divider_programming.sv
// Self-checking bench for the serial PLL divider block
`default_nettype none
module test_pll_serial_divider_programming;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, float_le, sdata, sclk, strb, strb_drv, busy;
   logic pol, pol_drv, lock, fl_o, fl_oe, mon, cp_o, cp_oe, sw, phr, pvo, pvoe;
   logic [pllsd_pkg::APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [18:0] frame;
   logic [4:0] nbits;
   logic [3:0] st_hist = 4'h0;
   logic [32:0] exp_q[$];
   logic [13:0] r;
   logic [10:0] n;
   logic [6:0] a;
   logic [17:0] mlast;
   int num_errors, checks, cycles, cnt_up, cnt_dn, cnt_unlock, i, per, u0, d0, l0;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   pllsd_top u_pllsd_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_data(sdata), .shift_clk(sclk), .latch_transfer_strobe(strb), .latch_transfer_strobe_drv(strb_drv),
      .phase_polarity_select(pol), .phase_polarity_select_drv(pol_drv), .osc_tick(1'b1), .vco_tick(1'b1),
      .lock_detect_out(lock), .fast_lock_switch_out_o(fl_o), .fast_lock_switch_out_oe(fl_oe),
      .divider_monitor_out(mon), .charge_pump_o(cp_o), .charge_pump_oe(cp_oe), .phase_ref_out(phr),
      .phase_vco_out_o(pvo), .phase_vco_out_oe(pvoe));
   pllsd_host_model u_pllsd_host_model (.pclk(pclk), .go(go), .frame(frame), .nbits(nbits), .float_le(float_le),
      .serial_data(sdata), .shift_clk(sclk), .strobe(strb), .strobe_drv(strb_drv), .busy(busy));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic err);
      exp_q.push_back({err, e});
      apb(ad, 1'b0, 32'h0000_0000);
   endtask
   task automatic send(input logic [18:0] f, input logic [4:0] nb, input logic fl);
      int k;
      frame <= f;
      nbits <= nb;
      float_le <= fl;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      for (k = 0; k < 400 && busy; k++) @(posedge pclk);
   endtask
   task automatic measure(output int pr);
      int k, c;
      logic p;
      pr = 0;
      repeat (3) begin
         c = 0;
         p = 1'b1;
         for (k = 0; k < 8000; k++) begin
            @(posedge pclk);
            c++;
            if (mon === 1'b1 && p === 1'b0) break;
            p = mon;
         end
         pr = c;
      end
   endtask
   // ----------------------------------------
   // Output watcher and timeout
   // ----------------------------------------
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) check("prdata", {pslverr, prdata}, exp_q.pop_front());
      st_hist <= {st_hist[2:0], strb_drv ? strb : 1'b1};
      if (st_hist == 4'h0 && presetn) check("fast_lock_oe", {63'h0, fl_oe}, 64'h0);
      else if (st_hist[0] && presetn) check("fast_lock_pin", {62'h0, fl_oe, fl_o && fl_oe}, {62'h0, cp_oe, cp_o && cp_oe});
      if (presetn) check("phase_pins", {60'h0, lock, phr, pvoe, pvo}, {60'h0, !cp_oe, cp_oe && !cp_o, cp_oe && cp_o, 1'b0});
      if (cp_oe === 1'b1 && cp_o === 1'b1) cnt_up++;
      if (cp_oe === 1'b1 && cp_o === 1'b0) cnt_dn++;
      if (lock === 1'b0) cnt_unlock++;
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, go, float_le} = 5'h00;
      paddr = '0;
      pwdata = 32'h0000_0000;
      frame = '0;
      nbits = 5'h10;
      {pol, pol_drv} = 2'b11;
      seed = 32'd37105;
      mlast = pllsd_pkg::MAIN_LATCH_RST;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(pllsd_pkg::REF_OFS, {17'h0, pllsd_pkg::REF_LATCH_RST}, 1'b0);
      rd(pllsd_pkg::MAIN_OFS, {14'h0, mlast}, 1'b0);
      rd(12'h014, 32'h0000_0000, 1'b1);
      apb(pllsd_pkg::CTRL_OFS, 1'b1, 32'h0000_0000);
      rd(pllsd_pkg::CTRL_OFS, 32'h0000_0000, 1'b0);
      apb(pllsd_pkg::CTRL_OFS, 1'b1, 32'h0000_0001);
      rd(pllsd_pkg::CTRL_OFS, 32'h0000_0001, 1'b0);
      for (i = 0; i < 2; i++) begin
         r = 14'(8 + xs() % 33);
         sw = i[0];
         n = 11'(16 + xs() % 8);
         a = 7'(xs() % n);
         send({3'h0, sw, r, 1'b1}, 5'd16, i[0]);
         rd(pllsd_pkg::REF_OFS, {17'h0, sw, r}, 1'b0);
         rd(pllsd_pkg::MAIN_OFS, {14'h0, mlast}, 1'b0);
         send({n, a, 1'b0}, 5'd19, 1'b0);
         mlast = {n, a};
         rd(pllsd_pkg::SHIFT_OFS, {13'h0, n, a, 1'b0}, 1'b0);
         rd(pllsd_pkg::MAIN_OFS, {14'h0, mlast}, 1'b0);
         rd(pllsd_pkg::REF_OFS, {17'h0, sw, r}, 1'b0);
         pol_drv <= 1'b0;
         pol <= 1'b0;
         u0 = cnt_up;
         d0 = cnt_dn;
         l0 = cnt_unlock;
         measure(per);
         check("ref_period", per, r);
         check("pump_up", (cnt_up - u0) > (cnt_dn - d0), 1);
         check("unlock_seen", (cnt_unlock - l0) > 0, 1);
         pol_drv <= 1'b1;
         u0 = cnt_up;
         d0 = cnt_dn;
         measure(per);
         check("vco_period", per, (sw ? 64 : 128) * n + a);
         check("pump_down", (cnt_dn - d0) > (cnt_up - u0), 1);
         pol <= 1'b1;
      end
      report_and_stop();
   end
endmodule // test_pll_serial_divider_programming
`default_nettype wire
